// file: host_fsm.sv
// One host control state machine, cleared by hard or soft reset.
// Assumes a start level from the same clock domain.
`timescale 1ns/1ps
module host_fsm (
   // Clock and resets
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic soft_rst,
   // Control
   input wire logic start,
   output logic busy
);
   import strap_pkg::*;
   host_state_t state_q;
   // ==========================================================
   // Sequencer: run until start falls, then settle
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         state_q <= HS_IDLE;
      end else begin
         case (state_q)
            HS_IDLE: if (start) state_q <= HS_RUN;
            HS_RUN: if (!start) state_q <= HS_DONE;
            HS_DONE: state_q <= HS_IDLE;
            default: state_q <= HS_IDLE;
         endcase
      end
   end
   assign busy = (state_q == HS_RUN);
endmodule // host_fsm

// file: strap_board.sv
// Board strap resistor model feeding the strap pixel bus.
// Assumes the block never drives the bus, so resistors set every line.
`timescale 1ns/1ps
module strap_board (
   // Variable board options
   input wire logic [63:0] options,
   // Resistor levels on the bus
   output logic [63:0] pins
);
   // ==========================================================
   // Fixed-value lines override the options
   always_comb begin
      pins = options;
      pins[4:0] = 5'h19;
      pins[15:6] = 10'h027;
      pins[38] = 1'b1;
      pins[39] = 1'b1;
      pins[47:40] = 8'hDF;
      pins[49:48] = 2'h3;
   end
endmodule // strap_board

// file: strap_loader.sv
// Reset handling and strap capture, with an AXI4-Lite register port.
// Assumes strap resistors hold the pixel bus static during hard reset.
`timescale 1ns/1ps
module strap_loader (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Strap pixel bus, undriven during reset
   input wire logic [63:0] strap_pixel_bus_in,
   output logic [63:0] strap_pixel_bus_out,
   output logic [63:0] strap_pixel_bus_oe_n,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Internal reset outputs
   output logic soft_reset_active,
   output logic fifo_clear,
   output logic draw_engine_clear,
   output logic legacy_video_clear,
   // Host machine triggers and status
   input wire logic [2:0] host_fsm_start,
   output logic [2:0] host_fsm_busy,
   // Loaded setup fields
   output logic [31:0] host_setup_q,
   output logic [31:0] operating_setup_q,
   output logic legacy_wakeup_port_enable_q
);
   import strap_pkg::*;

   logic [63:0] strap_sync_w;
   logic [31:0] strap_capture_low_q;
   logic [31:0] strap_capture_high_q;
   logic soft_bit_q;
   logic [31:0] soft_load_q;
   logic [31:0] draw_regs_q;
   logic capture_done_q;
   logic in_reset_q;
   logic [7:0] aw_addr_q;
   logic aw_held_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic w_held_q;
   logic wr_fire;
   logic [31:0] wr_mask;
   logic wr_hit;
   logic [31:0] rd_word;
   logic rd_hit;
   logic [1:0] vga_code;
   logic wakeup_d;

   // ==========================================================
   // Pins never driven; straps only sensed
   assign strap_pixel_bus_out = 64'h0000_0000_0000_0000;
   assign strap_pixel_bus_oe_n = 64'hFFFF_FFFF_FFFF_FFFF;

   strap_sync u_sync (
      .aclk(aclk),
      .pins(strap_pixel_bus_in),
      .synced(strap_sync_w)
   );

   // ==========================================================
   // Reset tracking; capture fires on first edge after release
   always_ff @(posedge aclk) begin
      in_reset_q <= !aresetn;
   end

   // Straps captured at release, synchroniser already settled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_done_q <= 1'b0;
      end else if (in_reset_q) begin
         capture_done_q <= 1'b1;
      end
   end

   // Capture registers, held across soft reset
   always_ff @(posedge aclk) begin
      if (aresetn && in_reset_q) begin
         strap_capture_low_q <= strap_sync_w[31:0];
         strap_capture_high_q <= strap_sync_w[63:32];
      end
   end

   // ==========================================================
   // Legacy enable decode: A alone gives wakeup port, B alone or both do not
   assign vga_code = (strap_sync_w[VGA_EN_A_LINE] || strap_sync_w[VGA_EN_B_LINE]) ? 2'h3 : 2'h0;
   assign wakeup_d = strap_sync_w[VGA_EN_A_LINE] && !strap_sync_w[VGA_EN_B_LINE];

   // Host setup: hard fields only from straps, soft from software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         host_setup_q <= ZERO32;
      end else if (in_reset_q) begin
         host_setup_q <= ZERO32;
         host_setup_q[CFG_MODE_LO +: 2] <= strap_sync_w[MODE_LO +: 2];
         host_setup_q[CFG_MAPSEL_LO +: 3] <= strap_sync_w[MAPSEL_LO +: 3];
         host_setup_q[CFG_ISA] <= strap_sync_w[ISA_LINE];
         host_setup_q[CFG_PCI] <= !strap_sync_w[PCI_LINE];
         host_setup_q[CFG_HIMEM] <= !strap_sync_w[HIMEM_LINE];
         host_setup_q[CFG_DRVRDY] <= !strap_sync_w[DRVRDY_LINE];
         host_setup_q[CFG_COMPANION_N] <= !strap_sync_w[COMPANION_N_LINE];
         host_setup_q[CFG_VGAEN_LO +: 2] <= vga_code;
         host_setup_q[CFG_WAKEUP] <= wakeup_d;
      end else begin
         // Software-loaded soft strap fields; hard fields untouched by soft reset
         host_setup_q[CFG_FASTDAC] <= soft_load_q[SL_FASTDAC];
         host_setup_q[CFG_SPARE] <= soft_load_q[SL_SPARE];
         host_setup_q[CFG_EXPDEV] <= soft_load_q[SL_EXPDEV];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         legacy_wakeup_port_enable_q <= 1'b0;
      end else if (in_reset_q) begin
         legacy_wakeup_port_enable_q <= wakeup_d;
      end
   end

   // Operating setup: bank-zero from strap, soft fields by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         operating_setup_q <= ZERO32;
      end else if (in_reset_q) begin
         operating_setup_q <= ZERO32;
         operating_setup_q[OPM_LEGACY_BANK0] <= strap_sync_w[VGA_BANK0_LINE];
      end else begin
         operating_setup_q[OPM_HYPER_LO +: 2] <= soft_load_q[SL_HYPER_LO +: 2];
         operating_setup_q[OPM_TRAM] <= soft_load_q[SL_TRAM];
      end
   end

   // ==========================================================
   // AXI write channel capture, either order
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= ZERO32;
         w_strb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // Byte-lane mask from strobes
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wr_mask[8*i +: 8] = {8{w_strb_q[i]}};
      end
   end

   assign wr_hit = (aw_addr_q == OFS_RESET) || (aw_addr_q == OFS_SOFT_LOAD) ||
      (aw_addr_q == OFS_STRAP_LOW) || (aw_addr_q == OFS_STRAP_HIGH) ||
      (aw_addr_q == OFS_HOST_CFG) || (aw_addr_q == OFS_OPERATING) || (aw_addr_q == OFS_STATUS);

   // Write response; unmapped addresses answer DECERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? 2'h0 : 2'h3;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Soft reset bit: held while it reads one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         soft_bit_q <= 1'b0;
      end else if (wr_fire && aw_addr_q == OFS_RESET && w_strb_q[0]) begin
         soft_bit_q <= w_data_q[0];
      end
   end

   // Soft strap load word written by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         soft_load_q <= ZERO32;
      end else if (wr_fire && aw_addr_q == OFS_SOFT_LOAD) begin
         soft_load_q <= (soft_load_q & ~wr_mask) | (w_data_q & wr_mask);
      end
   end

   // Internal reset fan-out
   assign soft_reset_active = soft_bit_q;
   assign fifo_clear = !aresetn || soft_bit_q;
   assign draw_engine_clear = !aresetn || soft_bit_q;
   assign legacy_video_clear = !aresetn;

   // Drawing register stand-in, lost on soft reset
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_bit_q) begin
         draw_regs_q <= ZERO32;
      end else if (wr_fire && aw_addr_q == OFS_STATUS) begin
         draw_regs_q <= (draw_regs_q & ~wr_mask) | (w_data_q & wr_mask);
      end
   end

   // ==========================================================
   // Three host machines cleared by soft reset
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_host
         host_fsm u_fsm (
            .aclk(aclk),
            .aresetn(aresetn),
            .soft_rst(soft_bit_q),
            .start(host_fsm_start[g]),
            .busy(host_fsm_busy[g])
         );
      end
   endgenerate

   // ==========================================================
   // Read path
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         OFS_STRAP_LOW: rd_word = strap_capture_low_q;
         OFS_STRAP_HIGH: rd_word = strap_capture_high_q;
         OFS_RESET: rd_word = {31'h0000_0000, soft_bit_q};
         OFS_HOST_CFG: rd_word = host_setup_q;
         OFS_OPERATING: rd_word = operating_setup_q;
         OFS_STATUS: rd_word = {draw_regs_q[31:4], host_fsm_busy, capture_done_q};
         OFS_SOFT_LOAD: rd_word = soft_load_q;
         default: begin
            rd_word = ZERO32;
            rd_hit = 1'b0;
         end
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= ZERO32;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? 2'h0 : 2'h3;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   a_capture_low_copy: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(capture_done_q) |-> strap_capture_low_q == $past(strap_sync_w[31:0]))
      else $error("low capture mismatch");
   a_capture_high_copy: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(capture_done_q) |-> strap_capture_high_q == $past(strap_sync_w[63:32]))
      else $error("high capture mismatch");
   a_soft_keeps_straps: assert property (@(posedge aclk) disable iff (!aresetn)
      capture_done_q && $past(capture_done_q) |-> $stable(strap_capture_low_q) && $stable(strap_capture_high_q))
      else $error("straps changed after capture");
   a_invert_pci_load: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(capture_done_q) |-> host_setup_q[CFG_PCI] == !strap_capture_high_q[PCI_LINE - 32])
      else $error("pci field not inverted");
   a_direct_mapsel_load: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(capture_done_q) |-> host_setup_q[CFG_MAPSEL_LO +: 3] == strap_capture_high_q[MAPSEL_LO - 32 +: 3])
      else $error("base window field wrong");
   a_soft_clears_fsm: assert property (@(posedge aclk) disable iff (!aresetn)
      soft_bit_q ##1 soft_bit_q |-> host_fsm_busy == 3'h0)
      else $error("host machine busy in soft reset");
   a_soft_follows_bit: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && aw_addr_q == OFS_RESET && w_strb_q[0] |=> soft_reset_active == $past(w_data_q[0]))
      else $error("soft reset not following bit");
   a_draw_lost_soft: assert property (@(posedge aclk) disable iff (!aresetn)
      soft_bit_q |=> draw_regs_q == ZERO32 && draw_engine_clear == soft_bit_q)
      else $error("drawing state kept in soft reset");
   a_wakeup_decode: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(capture_done_q) |-> legacy_wakeup_port_enable_q == (strap_capture_low_q[VGA_EN_A_LINE] &&
      !strap_capture_high_q[VGA_EN_B_LINE - 32]))
      else $error("wakeup port decode wrong");
   a_pins_undriven: assert property (@(posedge aclk) strap_pixel_bus_oe_n == 64'hFFFF_FFFF_FFFF_FFFF)
      else $error("strap pins driven");
   // ==========================================================
   // Hard reset and remaining strap loads; hard reset check has no disable, reset itself is watched
   a_hard_clears_state: assert property (@(posedge aclk) !aresetn |=> host_setup_q == ZERO32 &&
      !s_axi_bvalid && !s_axi_rvalid && !soft_bit_q)
      else $error("state kept through hard reset");
   a_invert_himem_load: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(capture_done_q) |-> host_setup_q[CFG_HIMEM] == !strap_capture_high_q[HIMEM_LINE - 32])
      else $error("high map field not inverted");
   a_direct_isa_load: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(capture_done_q) |-> host_setup_q[CFG_ISA] == strap_capture_high_q[ISA_LINE - 32])
      else $error("isa field wrong");
   a_legacy_code_load: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(capture_done_q) |-> host_setup_q[CFG_VGAEN_LO +: 2] == {2{strap_capture_low_q[VGA_EN_A_LINE] ||
      strap_capture_high_q[VGA_EN_B_LINE - 32]}})
      else $error("legacy enable code wrong");
   a_bank_zero_load: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(capture_done_q) |-> operating_setup_q[OPM_LEGACY_BANK0] == strap_capture_low_q[VGA_BANK0_LINE])
      else $error("bank zero field wrong");
endmodule // strap_loader

// file: strap_pkg.sv
// Constants for the reset and strap capture block.
// Assumes a 32-bit AXI4-Lite register port and a 10 MHz single clock.
// Functional notes
// - Hard reset clears everything and loads straps.
// - Soft reset is write one then zero.
// - Soft reset never resamples the straps.
// - Soft reset clears FIFO and drawing engine.
// - Soft reset clears all three host machines.
// - Strap lines copied into two capture registers.
// - Direct hard straps load uninverted.
// - Inverting hard straps load inverted.
// - Legacy enable straps decode port and bits.
// - Revision and platform codes exposed raw.
// - Bank presence from lines 32:25 and 35.
package strap_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_STRAP_LOW = 8'h00;
   localparam logic [7:0] OFS_STRAP_HIGH = 8'h04;
   localparam logic [7:0] OFS_RESET = 8'h08;
   localparam logic [7:0] OFS_HOST_CFG = 8'h0C;
   localparam logic [7:0] OFS_OPERATING = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_SOFT_LOAD = 8'h18;
   // ==========================================================
   // Strap bus line positions
   localparam int VGA_EN_A_LINE = 5;
   localparam int VGA_BANK0_LINE = 24;
   localparam int VGA_EN_B_LINE = 37;
   localparam int COMPANION_N_LINE = 50;
   localparam int ISA_LINE = 55;
   localparam int PCI_LINE = 56;
   localparam int HIMEM_LINE = 57;
   localparam int DRVRDY_LINE = 58;
   localparam int MAPSEL_LO = 59;
   localparam int MODE_LO = 62;
   localparam int BANK_LO = 25;
   localparam int BANK_TOP_LINE = 35;
   // ==========================================================
   // Host and operating setup field positions
   localparam int CFG_MODE_LO = 0;
   localparam int CFG_FASTDAC = 2;
   localparam int CFG_SPARE = 3;
   localparam int CFG_COMPANION_N = 4;
   localparam int CFG_DRVRDY = 8;
   localparam int CFG_VGAEN_LO = 9;
   localparam int CFG_HIMEM = 12;
   localparam int CFG_WAKEUP = 13;
   localparam int CFG_EXPDEV = 16;
   localparam int CFG_MAPSEL_LO = 24;
   localparam int CFG_PCI = 27;
   localparam int CFG_ISA = 28;
   localparam int OPM_LEGACY_BANK0 = 11;
   localparam int OPM_HYPER_LO = 24;
   localparam int OPM_TRAM = 26;
   // Soft-load register fields, software inverts or copies soft straps here
   localparam int SL_FASTDAC = 0;
   localparam int SL_SPARE = 1;
   localparam int SL_EXPDEV = 2;
   localparam int SL_TRAM = 3;
   localparam int SL_HYPER_LO = 4;
   // ==========================================================
   // Reset values
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   // Host state machine states
   typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_DONE} host_state_t;
endpackage

// file: strap_sync.sv
// Two-stage synchroniser for the 64 strap pins.
// Assumes the straps are static pin levels outside the clock domain.
`timescale 1ns/1ps
module strap_sync (
   // Clock
   input wire logic aclk,
   // Pins in, synchronised out
   input wire logic [63:0] pins,
   output logic [63:0] synced
);
   logic [63:0] meta_q;
   // ==========================================================
   // First stage read only by second
   always_ff @(posedge aclk) begin
      meta_q <= pins;
      synced <= meta_q;
   end
endmodule // strap_sync

// file: tb_top.sv
// Self-checking bench for the strap loader over AXI4-Lite.
// Assumes the strap_pkg offsets and a 10 MHz clock.
`timescale 1ns/1ps
module tb_top;
   import strap_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic awready, wready, bvalid, arready, rvalid;
   logic soft_act, fifo_clr, draw_clr, lvid_clr, wake;
   logic [2:0] fsm_start, fsm_busy;
   logic [31:0] setup, operating_setup_reg;
   logic [63:0] opts, pins, oe_n, cap, pout;
   logic [31:0] sl;
   logic [63:0] table_q [3] = '{64'hA884_0008_07AE_0020, 64'h1200_0020_006F_0000, 64'h0};
   int error_cnt = 0;
   int n_checks = 0;
   strap_board strap_board_inst (.options(opts), .pins(pins));
   strap_loader strap_loader_inst (.aclk(aclk), .aresetn(aresetn), .strap_pixel_bus_in(pins),
      .strap_pixel_bus_out(pout), .strap_pixel_bus_oe_n(oe_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .soft_reset_active(soft_act),
      .fifo_clear(fifo_clr), .draw_engine_clear(draw_clr), .legacy_video_clear(lvid_clr),
      .host_fsm_start(fsm_start), .host_fsm_busy(fsm_busy), .host_setup_q(setup),
      .operating_setup_q(operating_setup_reg), .legacy_wakeup_port_enable_q(wake));
   // ==========================================================
   // Clock, 100 ns period
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // ==========================================================
   // Compare and report
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // Bus cycles; each drives only after its own first edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (bvalid === 1'b1 && !aw && !w) break;
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar;
      ar = 1'b1;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (rvalid === 1'b1 && !ar) break;
         if (ar && arready === 1'b1) begin
            ar = 1'b0;
            arvalid <= 1'b0;
         end
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // ==========================================================
   // Hard reset with a given board option set
   task automatic hard_reset(input logic [63:0] p, input int hold);
      @(posedge aclk);
      opts <= p;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      chk({lvid_clr, fifo_clr, draw_clr}, 3'h7);
      repeat (hold - 2) @(posedge aclk);
      aresetn <= 1'b1;
      cap = pins;
      for (int i = 0; i < 20; i++) begin
         axi_rd(OFS_STATUS, rd, rsp);
         if (rd[0] === 1'b1) break;
      end
   endtask
   // Loaded host setup expected from the strap pattern
   function automatic logic [31:0] exp_setup(input logic [63:0] p);
      logic [31:0] e;
      e = 32'h0;
      e[1:0] = p[63:62];
      e[4] = ~p[50];
      e[8] = ~p[58];
      e[10:9] = {2{p[5] | p[37]}};
      e[12] = ~p[57];
      e[13] = p[5] & ~p[37];
      e[26:24] = p[61:59];
      e[27] = ~p[56];
      e[28] = p[55];
      return e;
   endfunction
   // ==========================================================
   // Watchdog, far beyond the expected 280 cycles
   initial begin
      #2_000_000;
      error_cnt++;
      final_report();
   end
   // ==========================================================
   // Test sequence
   initial begin
      aresetn = 1'b0;
      opts = table_q[0];
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      fsm_start = 3'h0;
      // Capture and load for three board option sets, incl. PCI set
      for (int k = 2; k >= 0; k--) begin
         hard_reset(table_q[k], (k == 2) ? 12 : 80);
         chk(oe_n, {64{1'b1}});
         chk(pout, 64'h0);
         axi_rd(OFS_STRAP_LOW, rd, rsp);
         chk(rd, cap[31:0]);
         axi_rd(OFS_STRAP_HIGH, rd, rsp);
         chk(rd, cap[63:32]);
         chk(setup, exp_setup(cap));
         axi_rd(OFS_HOST_CFG, rd, rsp);
         chk(rd, exp_setup(cap));
         chk(wake, cap[5] & ~cap[37]);
         chk(operating_setup_reg, {cap[24], 11'h0});
         $display("test strap_load %0d done", k);
      end
      // Read-only write ignored, unmapped place refused
      axi_wr(OFS_STRAP_LOW, 32'h1234_5678, rsp);
      chk(rsp, 2'h0);
      axi_rd(OFS_STRAP_LOW, rd, rsp);
      chk(rd, cap[31:0]);
      axi_wr(8'hFC, 32'hFFFF_FFFF, rsp);
      chk(rsp, 2'h3);
      axi_rd(8'hFC, rd, rsp);
      chk({rsp, rd}, {2'h3, 32'h0});
      $display("test bus_map done");
      // Soft reset: drawing state and host machines cleared, straps kept
      axi_wr(OFS_STATUS, 32'hABCD_EF00, rsp);
      axi_rd(OFS_STATUS, rd, rsp);
      chk(rd, 32'hABCD_EF01);
      fsm_start <= 3'h7;
      repeat (4) @(posedge aclk);
      chk(fsm_busy, 3'h7);
      opts <= table_q[2];
      axi_wr(OFS_RESET, 32'h1, rsp);
      repeat (2) @(posedge aclk);
      chk({soft_act, fifo_clr, draw_clr, lvid_clr}, 4'hE);
      chk(fsm_busy, 3'h0);
      fsm_start <= 3'h0;
      axi_rd(OFS_RESET, rd, rsp);
      chk(rd[0], 1'b1);
      axi_wr(OFS_RESET, 32'h0, rsp);
      repeat (3) @(posedge aclk);
      chk({soft_act, fifo_clr, draw_clr}, 3'h0);
      axi_rd(OFS_STATUS, rd, rsp);
      chk(rd, 32'h0000_0001);
      axi_rd(OFS_STRAP_HIGH, rd, rsp);
      chk(rd, cap[63:32]);
      chk(setup, exp_setup(cap));
      $display("test soft_reset done");
      // Software inverts or copies soft straps into the load word
      axi_rd(OFS_STRAP_HIGH, rd, rsp);
      sl = {26'h0, rd[20:19], rd[22], rd[21], ~rd[17], ~rd[16]};
      axi_wr(OFS_SOFT_LOAD, sl, rsp);
      repeat (2) @(posedge aclk);
      chk(setup, exp_setup(cap) | {15'h0, sl[2], 12'h0, sl[1:0], 2'h0});
      chk(operating_setup_reg, {5'h0, sl[3], sl[5:4], 12'h0, cap[24], 11'h0});
      axi_wr(OFS_SOFT_LOAD, 32'h0000_003F, rsp);
      repeat (2) @(posedge aclk);
      chk(setup, exp_setup(cap) | 32'h0001_000C);
      chk(operating_setup_reg, {5'h0, 3'h7, 12'h0, cap[24], 11'h0});
      axi_rd(OFS_SOFT_LOAD, rd, rsp);
      chk({rsp, rd}, {2'h0, 32'h0000_003F});
      $display("test soft_load done");
      final_report();
   end
endmodule // tb_top
